// ==== hw/dsz_deser_out.sv ====
/*
  Output qualification and control of a three-lane, 21-bit deserializer:
  fail-safe squelch, clock-activity detection, power-down, lock counting,
  balance decoding and the parallel output strobe.
  Assumes clk at 125 MHz, link_clk as the link bit clock in its own domain,
  and pin inputs that are asynchronous to both clocks.
*/
// Contract
// - in plain mode a lane whose input is open or undriven drives its outputs low.
// - in plain mode a fail-safe condition on the link clock drives every output low.
// - in balanced mode the input fail-safe squelch is ignored entirely.
// - in balanced mode a stopped or too slow link clock drives every output low.
// - while power-down is low the outputs float and the PLL is halted.
// - after power-down rises every output is held low until lock.
// - lock is declared after a counted number of link clock periods, at most 32,800.
// - lock is reached whatever order clock and power-down release arrive in.
// - in the rising variant data is captured on the strobe's rising edge.
// - in the falling variant data is captured on the strobe's falling edge.
// - either strobe variant works with a serializer that latches on its rising edge.
// - in balanced mode a lane biased statically negative yields low outputs.
// - the mode select high picks balanced operation, low picks plain operation.
// - each lane gives 7 bits per period in plain mode, 9 in balanced mode.
// - in balanced mode the two appended bits tell whether a group was inverted.
`timescale 1ns/100ps
`default_nettype none
`include "dsz_consts.svh"
module dsz_deser_out #(
  parameter int LOCK_PERIODS = `DSZ_LOCK_PERIODS,
  parameter bit FALL_STROBE  = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  link_clk,
  input  wire logic                  link_clock_in,
  input  wire logic [`DSZ_LANES-1:0] serial_lane_in,
  input  wire logic [`DSZ_LANES-1:0] lane_failsafe,
  input  wire logic                  clock_failsafe,
  input  wire logic                  power_down_n,
  input  wire logic                  balance_mode_select,
  input  wire logic                  sink_ready,
  output logic [`DSZ_OUT_W-1:0]      parallel_data_out,
  output logic                       parallel_data_oe,
  output logic                       parallel_strobe_out,
  output logic                       parallel_strobe_oe,
  output logic                       pll_running,
  output logic                       locked,
  output logic                       overrun
);
  localparam int RAW_W = $bits(dsz_pkg::dsz_raw_t);
  localparam logic [`DSZ_LOCK_W-1:0] LOCK_LAST = `DSZ_LOCK_W'(LOCK_PERIODS - 1);
  localparam logic [`DSZ_IDLE_W-1:0] LOSS_CYC  = `DSZ_IDLE_W'(`DSZ_LOSS_CYC);
  // level of the strobe edge on which the receiver captures
  localparam logic STROBE_ACT = !FALL_STROBE;

  dsz_pkg::dsz_main_st_t s;
  dsz_pkg::dsz_main_st_t next_s;

  dsz_pkg::dsz_raw_t link_word;
  logic              link_tgl;
  logic              frame_evt;
  logic              clk_lost;
  logic              fifo_flush;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [RAW_W-1:0]  fifo_out_data;
  dsz_pkg::dsz_raw_t fifo_word;

  // restores one 7-bit group; the balance pair must be complementary, so a
  // lane resting at negative differential (all zeros) decodes to zeros
  function automatic logic [`DSZ_BITS_PLAIN-1:0] lane_decode(
    input dsz_pkg::dsz_lane_raw_t raw,
    input logic                   dcb,
    input logic                   fault
  );
    logic [1:0] bal;
    bal = raw[`DSZ_BAL_MSB:`DSZ_BAL_LSB];
    if (dcb) begin
      unique case (bal)
        `DSZ_BAL_PLAIN: lane_decode = raw[`DSZ_BITS_PLAIN-1:0];
        `DSZ_BAL_INV:   lane_decode = ~raw[`DSZ_BITS_PLAIN-1:0];
        default:        lane_decode = '0;
      endcase
    end else if (fault) begin
      lane_decode = '0;
    end else begin
      lane_decode = raw[`DSZ_BITS_PLAIN-1:0];
    end
  endfunction

  // PLL stand-in; it halts from the synchronised power-down level
  dsz_link u_link (
    .link_clk            (link_clk),
    .rst_n               (rst_n),
    .run_req             (s.pll_run),
    .balance_mode_select (balance_mode_select),
    .link_clock_in       (link_clock_in),
    .serial_lane_in      (serial_lane_in),
    .word                (link_word),
    .frame_tgl           (link_tgl)
  );

  // with the holding register, absorbs a receiver stall of up to three words before a frame is dropped
  dsz_fifo #(
    .W (RAW_W),
    .D (`DSZ_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .flush     (fifo_flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (s.pend),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_word = dsz_pkg::dsz_raw_t'(fifo_out_data);

  // one toggle per link clock period; the word behind it is stable for a
  // whole period, far longer than the three-flop crossing takes
  assign frame_evt = s.tg_s2 ^ s.tg_s3;

  // balanced mode watches clock activity; plain mode trusts the fail-safe
  assign clk_lost = s.dcb_s2 ? (s.idle_cnt >= LOSS_CYC)
                             : s.cf_s2;

  assign fifo_in_valid  = s.pend_vld && (s.ost == dsz_pkg::DSZ_RUN);
  assign fifo_out_ready = (s.ost == dsz_pkg::DSZ_RUN) && !clk_lost && !s.ph && sink_ready;
  assign fifo_flush     = (s.ost != dsz_pkg::DSZ_RUN) || clk_lost;

  assign parallel_data_out   = s.data;
  assign parallel_data_oe    = s.oe;
  assign parallel_strobe_out = s.strobe;
  assign parallel_strobe_oe  = s.oe;
  assign pll_running         = s.pll_run;
  assign locked              = (s.ost == dsz_pkg::DSZ_RUN);
  assign overrun             = s.overrun;

  always_comb begin
    next_s         = s;
    next_s.pd_s1   = power_down_n;
    next_s.pd_s2   = s.pd_s1;
    next_s.dcb_s1  = balance_mode_select;
    next_s.dcb_s2  = s.dcb_s1;
    next_s.lf_s1   = lane_failsafe;
    next_s.lf_s2   = s.lf_s1;
    next_s.cf_s1   = clock_failsafe;
    next_s.cf_s2   = s.cf_s1;
    next_s.tg_s1   = link_tgl;
    next_s.tg_s2   = s.tg_s1;
    next_s.tg_s3   = s.tg_s2;
    next_s.overrun = 1'b0;

    // clock-activity timer, saturating at the loss threshold
    if (frame_evt) begin
      next_s.idle_cnt = '0;
    end else if (s.idle_cnt < LOSS_CYC) begin
      next_s.idle_cnt = s.idle_cnt + 1'b1;
    end

    // holding register between the crossing and the buffer; a full buffer
    // stalls it, and a frame arriving while it is still full is dropped
    if (fifo_in_valid && fifo_in_ready) begin
      next_s.pend_vld = 1'b0;
    end
    if (frame_evt) begin
      if (next_s.pend_vld) begin
        next_s.overrun = (s.ost == dsz_pkg::DSZ_RUN);
      end else begin
        next_s.pend     = link_word;
        next_s.pend_vld = 1'b1;
      end
    end

    if (!s.pd_s2) begin
      // outputs float, PLL stops, everything restarts from scratch
      next_s.ost      = dsz_pkg::DSZ_OFF;
      next_s.oe       = 1'b0;
      next_s.pll_run  = 1'b0;
      next_s.data     = '0;
      next_s.strobe   = 1'b0;
      next_s.ph       = 1'b0;
      next_s.lock_cnt = '0;
      next_s.pend_vld = 1'b0;
    end else begin
      next_s.oe      = 1'b1;
      next_s.pll_run = 1'b1;
      unique case (s.ost)
        dsz_pkg::DSZ_OFF: begin
          // driven low from the third clock edge after power-down rises, once synchronised
          next_s.ost      = dsz_pkg::DSZ_ACQ;
          next_s.lock_cnt = '0;
          next_s.data     = '0;
          next_s.strobe   = 1'b0;
        end
        dsz_pkg::DSZ_ACQ: begin
          next_s.data     = '0;
          next_s.strobe   = 1'b0;
          next_s.ph       = 1'b0;
          next_s.pend_vld = 1'b0;
          // counting only starts once the clock is present, so no order of
          // clock start and power-down release can strand the counter
          if (clk_lost) begin
            next_s.lock_cnt = '0;
          end else if (frame_evt) begin
            if (s.lock_cnt == LOCK_LAST) begin
              next_s.ost      = dsz_pkg::DSZ_RUN;
              next_s.lock_cnt = '0;
            end else begin
              next_s.lock_cnt = s.lock_cnt + 1'b1;
            end
          end
        end
        dsz_pkg::DSZ_RUN: begin
          if (clk_lost) begin
            // all outputs low and a fresh lock count
            next_s.ost      = dsz_pkg::DSZ_ACQ;
            next_s.lock_cnt = '0;
            next_s.data     = '0;
            next_s.strobe   = 1'b0;
            next_s.ph       = 1'b0;
            next_s.pend_vld = 1'b0;
          end else if (s.ph) begin
            // active edge one cycle after the data settle
            next_s.strobe = STROBE_ACT;
            next_s.ph     = 1'b0;
          end else if (fifo_out_valid && sink_ready) begin
            for (int i = 0; i < `DSZ_LANES; i++) begin
              next_s.data[i*`DSZ_BITS_PLAIN +: `DSZ_BITS_PLAIN] =
                lane_decode(fifo_word.lane[i], s.dcb_s2, s.lf_s2[i]);
            end
            next_s.strobe = !STROBE_ACT;
            next_s.ph     = 1'b1;
          end
        end
        default: begin
          next_s.ost = dsz_pkg::DSZ_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ==== hw/dsz_consts.svh ====
/*
  Constants of the deserializer output control: lane geometry, balance codes,
  lock and clock-loss timing. Assumes the core clock runs at 125 MHz.
*/
`ifndef DSZ_CONSTS_SVH
`define DSZ_CONSTS_SVH

`define DSZ_LANES         3
`define DSZ_BITS_PLAIN    7
`define DSZ_BITS_DCB      9
`define DSZ_OUT_W         21
`define DSZ_BAL_MSB       8
`define DSZ_BAL_LSB       7
`define DSZ_BAL_PLAIN     2'h1
`define DSZ_BAL_INV       2'h2
`define DSZ_LOCK_PERIODS  32800
`define DSZ_LOCK_W        16
`define DSZ_CLK_PERIOD_NS 8
`define DSZ_LOSS_TIME_NS  250
`define DSZ_LOSS_CYC      (`DSZ_LOSS_TIME_NS / `DSZ_CLK_PERIOD_NS)
`define DSZ_IDLE_W        6
`define DSZ_FIFO_DEPTH    2

`endif

// ==== hw/dsz_pkg.sv ====
/*
  Types shared by the deserializer output control modules.
  Assumes dsz_consts.svh is on the include path.
*/
`include "dsz_consts.svh"
package dsz_pkg;
  typedef logic [`DSZ_BITS_DCB-1:0] dsz_lane_raw_t;

  typedef struct packed {
    dsz_lane_raw_t [`DSZ_LANES-1:0] lane;
  } dsz_raw_t;

  typedef enum logic [1:0] {
    DSZ_OFF = 2'h0,
    DSZ_ACQ = 2'h1,
    DSZ_RUN = 2'h2
  } dsz_ost_t;

  typedef struct packed {
    logic                  run_s1;
    logic                  run_s2;
    logic                  dcb_s1;
    logic                  dcb_s2;
    logic                  ck_s1;
    logic                  ck_s2;
    logic                  ck_s3;
    logic [`DSZ_LANES-1:0] ln_s1;
    logic [`DSZ_LANES-1:0] ln_s2;
    dsz_raw_t              sh;
    dsz_raw_t              word;
    logic                  tgl;
  } dsz_link_st_t;

  typedef struct packed {
    logic                   pd_s1;
    logic                   pd_s2;
    logic                   dcb_s1;
    logic                   dcb_s2;
    logic [`DSZ_LANES-1:0]  lf_s1;
    logic [`DSZ_LANES-1:0]  lf_s2;
    logic                   cf_s1;
    logic                   cf_s2;
    logic                   tg_s1;
    logic                   tg_s2;
    logic                   tg_s3;
    logic                   pend_vld;
    dsz_raw_t               pend;
    dsz_ost_t               ost;
    logic [`DSZ_LOCK_W-1:0] lock_cnt;
    logic [`DSZ_IDLE_W-1:0] idle_cnt;
    logic [`DSZ_OUT_W-1:0]  data;
    logic                   strobe;
    logic                   ph;
    logic                   oe;
    logic                   pll_run;
    logic                   overrun;
  } dsz_main_st_t;
endpackage

// ==== hw/dsz_fifo.sv ====
/*
  Two-entry buffer with valid/ready on both sides and a synchronous flush.
  Assumes one clock, async active-low reset, clock enable freezing all state.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsz_consts.svh"
module dsz_fifo #(
  parameter int W = 27,
  parameter int D = `DSZ_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } fifo_st_t;

  fifo_st_t s;
  fifo_st_t next_s;
  logic     push;
  logic     pop;

  assign in_ready  = (s.cnt != CW'(D));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    if (flush) begin
      next_s.wp  = '0;
      next_s.rp  = '0;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ==== hw/dsz_link.sv ====
/*
  Link-side capture: samples the clock lane and three data lanes on the
  bit-rate link clock and hands one raw word per link clock period to the
  core domain, held stable with a toggle. Assumes the bit clock stands in
  for the multiplied PLL output; it stops while the PLL is halted.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsz_consts.svh"
module dsz_link (
  input  wire logic                  link_clk,
  input  wire logic                  rst_n,
  input  wire logic                  run_req,
  input  wire logic                  balance_mode_select,
  input  wire logic                  link_clock_in,
  input  wire logic [`DSZ_LANES-1:0] serial_lane_in,
  output dsz_pkg::dsz_raw_t          word,
  output logic                       frame_tgl
);
  dsz_pkg::dsz_link_st_t s;
  dsz_pkg::dsz_link_st_t next_s;

  assign word      = s.word;
  assign frame_tgl = s.tgl;

  always_comb begin
    next_s        = s;
    next_s.run_s1 = run_req;
    next_s.run_s2 = s.run_s1;
    next_s.dcb_s1 = balance_mode_select;
    next_s.dcb_s2 = s.dcb_s1;
    next_s.ck_s1  = link_clock_in;
    next_s.ck_s2  = s.ck_s1;
    next_s.ck_s3  = s.ck_s2;
    next_s.ln_s1  = serial_lane_in;
    next_s.ln_s2  = s.ln_s1;
    if (s.run_s2) begin
      for (int i = 0; i < `DSZ_LANES; i++) begin
        next_s.sh.lane[i] = {s.ln_s2[i], s.sh.lane[i][`DSZ_BITS_DCB-1:1]};
      end
      // frame boundary at the clock lane's rising edge; word length by mode
      if (s.ck_s2 && !s.ck_s3) begin
        for (int i = 0; i < `DSZ_LANES; i++) begin
          next_s.word.lane[i] = s.dcb_s2 ? next_s.sh.lane[i]
              : {2'h0, next_s.sh.lane[i][`DSZ_BITS_DCB-1:`DSZ_BITS_DCB-`DSZ_BITS_PLAIN]};
        end
        next_s.tgl = !s.tgl;
      end
    end else begin
      // halted PLL: nothing is shifted or handed over
      next_s.sh = '0;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ==== test/dsz_deser_out_chk.sv ====
/*
  Port checker of the deserializer output control, bound to every instance.
  Assumes one core clock domain and a bench that holds ce high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsz_consts.svh"
module dsz_deser_out_chk #(
  parameter int LOCK_PERIODS = 8,
  parameter bit FALL_STROBE  = 1'b0
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  ce,
  input wire logic                  link_clk,
  input wire logic                  link_clock_in,
  input wire logic [`DSZ_LANES-1:0] serial_lane_in,
  input wire logic [`DSZ_LANES-1:0] lane_failsafe,
  input wire logic                  clock_failsafe,
  input wire logic                  power_down_n,
  input wire logic                  balance_mode_select,
  input wire logic                  sink_ready,
  input wire logic [`DSZ_OUT_W-1:0] parallel_data_out,
  input wire logic                  parallel_data_oe,
  input wire logic                  parallel_strobe_out,
  input wire logic                  parallel_strobe_oe,
  input wire logic                  pll_running,
  input wire logic                  locked,
  input wire logic                  overrun
);
  logic [15:0] run_cyc;
  logic [5:0]  idle;
  // frames come at least 4 core cycles apart, so lock can never be quicker than this
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_cyc <= 16'h0;
      idle    <= 6'h0;
    end else begin
      run_cyc <= !pll_running ? 16'h0 : run_cyc + {15'h0, run_cyc != 16'hffff};
      idle    <= $changed(link_clock_in) ? 6'h0 : idle + {5'h0, idle != 6'h3f};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_pair: assert property (parallel_strobe_oe == parallel_data_oe)
    else $error("strobe and data enables differ");
  a_pd_float: assert property ((!power_down_n && ce) [*3] |=> !parallel_data_oe && !pll_running)
    else $error("outputs driven or pll running in power down");
  a_oe_cause: assert property ($rose(parallel_data_oe) |-> $past(power_down_n, 3))
    else $error("outputs enabled without power up");
  a_acq_low: assert property (!locked |-> parallel_data_out == '0 && !parallel_strobe_out)
    else $error("outputs not low before lock");
  a_lock_time: assert property ($rose(locked) |-> run_cyc >= 16'(LOCK_PERIODS * 4))
    else $error("lock declared too early");
  a_strobe_edge: assert property (locked && $changed(parallel_data_out) |->
    parallel_strobe_out == FALL_STROBE ##1 (parallel_strobe_out != FALL_STROBE || !locked))
    else $error("strobe edge not after data change");
  a_stall_hold: assert property (locked && !sink_ready |=> $stable(parallel_data_out) || !locked)
    else $error("data changed while sink stalls");
  a_plain_loss: assert property ((clock_failsafe && !balance_mode_select && ce) [*4] |->
    !locked && parallel_data_out == '0)
    else $error("clock fail-safe did not squelch outputs");
  a_dcb_idle: assert property (balance_mode_select && idle == 6'h30 |-> !locked)
    else $error("stopped link clock not detected");
endmodule
bind dsz_deser_out dsz_deser_out_chk #(.LOCK_PERIODS(LOCK_PERIODS), .FALL_STROBE(FALL_STROBE))
  u_chk (.clk, .rst_n, .ce, .link_clk, .link_clock_in, .serial_lane_in, .lane_failsafe,
  .clock_failsafe, .power_down_n, .balance_mode_select, .sink_ready, .parallel_data_out,
  .parallel_data_oe, .parallel_strobe_out, .parallel_strobe_oe, .pll_running, .locked, .overrun);
`default_nettype wire

// ==== test/dsz_ser_model.sv ====
/*
  Behavioural serializer on the link: clock lane plus three data lanes.
  Assumes link_clk is the bit clock; the clock lane stands still when stopped.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsz_consts.svh"
module dsz_ser_model (
  input  wire logic                  link_clk,
  input  wire logic                  run,
  input  wire logic                  dcb,
  input  wire logic [`DSZ_LANES-1:0] neg,
  input  wire logic [`DSZ_OUT_W-1:0] word,
  output logic                       link_clock_in,
  output logic [`DSZ_LANES-1:0]      serial_lane_in
);
  logic [3:0] k;
  logic       inv;
  logic [8:0] f [3];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      f[i] = inv ? {2'b10, ~word[7*i +: 7]} : {2'b01, word[7*i +: 7]};
      if (neg[i]) f[i] = 9'h0;
    end
  end
  initial begin
    k = 4'h0;
    inv = 1'b0;
    link_clock_in = 1'b0;
    serial_lane_in = '0;
  end
  // parallel word is taken on the rising bit edge, whatever the receiver strobe
  always @(posedge link_clk) begin
    if (!run) begin
      k <= 4'h0;
      link_clock_in <= 1'b0;
      serial_lane_in <= ~serial_lane_in;
    end else begin
      // clock lane rises with the last bit, where the receiver closes a group
      link_clock_in <= (k == (dcb ? 4'h8 : 4'h6)) || (k < 4'h3);
      for (int i = 0; i < 3; i++) serial_lane_in[i] <= f[i][k];
      // wrap at or past the end so a mode change mid-group never runs k off the word
      k <= (k >= (dcb ? 4'h8 : 4'h6)) ? 4'h0 : k + 4'h1;
      if (k >= (dcb ? 4'h8 : 4'h6)) inv <= dcb & ~inv;
    end
  end
endmodule
`default_nettype wire

// ==== test/test_dsz_deser_out.sv ====
/*
  Self-checking bench: rising and falling strobe instances fed by one serializer.
  Assumes LOCK_PERIODS shortened to 8 and the sink able to capture except during the stall test.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsz_consts.svh"
module test_dsz_deser_out;
  logic clk, link_clk, rst_n, ce, run, dcb, clk_fs, pd, pd_f, sink_ready;
  logic [2:0]  neg, lane_fs;
  logic [20:0] word, w0;
  wire logic [2:0]  sli;
  wire logic [20:0] dout, dout_f;
  wire logic lci, oe, oe_f, sout, sout_f, pllr, lck, ovr;
  int fail_count, checked;
  dsz_ser_model u_ser (.link_clk(link_clk), .run(run), .dcb(dcb), .neg(neg), .word(word),
    .link_clock_in(lci), .serial_lane_in(sli));
  dsz_deser_out #(.LOCK_PERIODS(8)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .link_clk(link_clk), .link_clock_in(lci), .serial_lane_in(sli), .lane_failsafe(lane_fs),
    .clock_failsafe(clk_fs), .power_down_n(pd), .balance_mode_select(dcb),
    .sink_ready(sink_ready), .parallel_data_out(dout), .parallel_data_oe(oe),
    .parallel_strobe_out(sout), .parallel_strobe_oe(), .pll_running(pllr), .locked(lck),
    .overrun(ovr));
  dsz_deser_out #(.LOCK_PERIODS(8), .FALL_STROBE(1'b1)) u_dut_fall (.clk(clk), .rst_n(rst_n),
    .ce(ce), .link_clk(link_clk), .link_clock_in(lci), .serial_lane_in(sli),
    .lane_failsafe(lane_fs), .clock_failsafe(clk_fs), .power_down_n(pd_f),
    .balance_mode_select(dcb), .sink_ready(sink_ready), .parallel_data_out(dout_f),
    .parallel_data_oe(oe_f), .parallel_strobe_out(sout_f), .parallel_strobe_oe(),
    .pll_running(), .locked(), .overrun());
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  task automatic results;
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // capture at the active strobe edge, seen between falling clock edges
  task automatic want(input logic [20:0] e, input bit f);
    logic p;
    logic [20:0] w;
    step(40);
    @(negedge clk);
    p = f ? ~sout_f : sout;
    w = 'x;
    for (int n = 0; n < 200; n++) begin
      @(negedge clk);
      if ((f ? ~sout_f : sout) && !p) begin
        w = f ? dout_f : dout;
        break;
      end
      p = f ? ~sout_f : sout;
    end
    chk(w === e, "captured word differs");
    step(1);
  endtask
  task automatic relock;
    for (int n = 0; n < 400 && lck !== 1'b1; n++) @(negedge clk);
    chk(lck === 1'b1, "no lock");
    step(1);
  endtask
  task automatic t_power;
    step(10);
    chk(oe === 1'b0 && pllr === 1'b0, "driving in power down");
    pd <= 1'b1;
    pd_f <= 1'b1;
    step(10);
    chk(oe === 1'b1 && dout === 21'h0 && lck === 1'b0, "outputs not low");
    step(40);
    chk(lck === 1'b0, "lock without clock");
    run <= 1'b1;
    relock();
  endtask
  task automatic t_dcb;
    logic [20:0] tbl [3];
    tbl = '{21'h0a5f3c, 21'h1fffff, 21'h12d0e1};
    foreach (tbl[i]) begin
      word <= tbl[i];
      want(tbl[i], 1'b0);
      want(tbl[i], 1'b1);
    end
    lane_fs <= 3'h1;
    want(word, 1'b0);
    lane_fs <= 3'h0;
    neg <= 3'h2;
    want(word & 21'h1fc07f, 1'b0);
    neg <= 3'h0;
  endtask
  task automatic t_plain;
    dcb <= 1'b0;
    word <= 21'h15a3c6;
    want(21'h15a3c6, 1'b0);
    lane_fs <= 3'h4;
    want(21'h0023c6, 1'b0);
    lane_fs <= 3'h0;
    clk_fs <= 1'b1;
    step(8);
    chk(lck === 1'b0 && dout === 21'h0, "clock fail-safe ignored");
    clk_fs <= 1'b0;
    relock();
    dcb <= 1'b1;
    want(21'h15a3c6, 1'b0);
  endtask
  task automatic t_loss;
    run <= 1'b0;
    step(60);
    chk(lck === 1'b0 && dout === 21'h0, "clock loss missed");
    run <= 1'b1;
    relock();
  endtask
  task automatic t_stall;
    bit seen;
    seen = 1'b0;
    sink_ready <= 1'b0;
    step(5);
    w0 = dout;
    word <= 21'h0c3a5f;
    for (int n = 0; n < 80; n++) begin
      @(negedge clk);
      if (ovr === 1'b1) seen = 1'b1;
    end
    chk(seen && dout === w0, "stall lost hold or no overrun");
    step(1);
    sink_ready <= 1'b1;
    want(21'h0c3a5f, 1'b0);
  endtask
  task automatic t_mux;
    pd_f <= 1'b0;
    pd <= 1'b0;
    step(13);
    pd_f <= 1'b1;
    step(5);
    chk(oe === 1'b0 && oe_f === 1'b1, "bused outputs not swapped");
  endtask
  initial begin
    fail_count = 0;
    checked = 0;
    {rst_n, run, clk_fs, pd, pd_f} = '0;
    {ce, dcb, sink_ready} = 3'h7;
    neg = 3'h0;
    lane_fs = 3'h0;
    word = 21'h0;
    step(8);
    rst_n <= 1'b1;
    t_power();
    t_dcb();
    t_plain();
    t_loss();
    t_stall();
    t_mux();
    results();
  end
  initial begin
    #200000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
